// file: core/gptsc_pkg.sv
// Types shared by the timer and slow clock block
package gptsc_pkg;

  typedef enum logic [1:0] {
    TICK_OFF,
    TICK_SIXTEENTH,
    TICK_SECOND,
    TICK_MINUTE
  } gptsc_tick_e;

  typedef enum logic [1:0] {
    OSEL_FIXED,
    OSEL_1HZ,
    OSEL_4HZ,
    OSEL_16HZ
  } gptsc_osel_e;

  typedef enum logic [1:0] {
    TMR_STOPPED,
    TMR_RUNNING,
    TMR_EXPIRED
  } gptsc_tmr_state_e;

  typedef struct packed {
    logic sixteenth;
    logic second;
    logic minute;
    logic sq1Hz;
    logic sq4Hz;
    logic sq16Hz;
  } gptsc_ticks_s;

  typedef struct packed {
    logic        start;
    logic        autoReload;
    gptsc_tick_e tickSel;
    logic [7:0]  loadValue;
  } gptsc_timer_cfg_s;

endpackage : gptsc_pkg

// file: core/gptsc_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef GPTSC_REGS_SVH
`define GPTSC_REGS_SVH

// ==========================================================
// Register offsets
`define GPTSC_OFF_STATUS   8'h28
`define GPTSC_OFF_SMIEN    8'h2A
`define GPTSC_OFF_RLDEN    8'h38
`define GPTSC_OFF_OUTLVL   8'h4C
`define GPTSC_OFF_CTRL     8'h90
`define GPTSC_OFF_MISC1    8'h94
`define GPTSC_OFF_MISC2    8'h95

// ==========================================================
// Timer control fields
`define GPTSC_B_CNT_HI     23
`define GPTSC_B_CNT_LO     16
`define GPTSC_A_CNT_HI     15
`define GPTSC_A_CNT_LO     8
`define GPTSC_B_START      7
`define GPTSC_B_AUTO       6
`define GPTSC_B_TICK_HI    5
`define GPTSC_B_TICK_LO    4
`define GPTSC_A_START      3
`define GPTSC_A_AUTO       2
`define GPTSC_A_TICK_HI    1
`define GPTSC_A_TICK_LO    0

// ==========================================================
// Status, enable and misc fields
`define GPTSC_STAT_B       3
`define GPTSC_STAT_A       2
`define GPTSC_OSEL_HI      1
`define GPTSC_OSEL_LO      0
`define GPTSC_PADMUX_BIT   1
`define GPTSC_OUTLVL_BIT   7

// ==========================================================
// Reset values
`define GPTSC_MISC1_RST    8'h88
`define GPTSC_MISC2_RST    8'h40
`define GPTSC_BYTE_ZERO    8'h00
`define GPTSC_WORD_ZERO    32'h0000_0000
`define GPTSC_COUNT_ONE    8'h01

// ==========================================================
// Slow reference timing
`define GPTSC_REF_HZ           32768
`define GPTSC_SIXTEENTHS_SEC   16
`define GPTSC_SECONDS_MIN      60
`define GPTSC_REF_PER_SIXTEENTH (`GPTSC_REF_HZ / `GPTSC_SIXTEENTHS_SEC)

`endif

// file: core/gptsc_tick_gen.sv
// Slow reference divider: timer ticks and slow square waves
`timescale 1ns/100ps
`default_nettype none
`include "gptsc_regs.svh"

module gptsc_tick_gen #(
  parameter int REF_PER_SIXTEENTH = `GPTSC_REF_PER_SIXTEENTH
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   slowRefClk,
  output gptsc_pkg::gptsc_ticks_s     ticks
);

  logic        refMeta;
  logic        refSync;
  logic        refLast;
  logic        refEdge;
  logic [15:0] preCount;
  logic [3:0]  sixteenthCount;
  logic [5:0]  secondCount;
  logic        preWrap;

  // ==========================================================
  // Reference synchroniser
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      refMeta <= 1'b0;
      refSync <= 1'b0;
      refLast <= 1'b0;
    end else begin
      refMeta <= slowRefClk;
      refSync <= refMeta;
      refLast <= refSync;
    end
  end

  assign refEdge = refSync & ~refLast;
  assign preWrap = refEdge && (preCount == 16'(REF_PER_SIXTEENTH - 1));

  // ==========================================================
  // Divider chain from the always-on reference
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      preCount       <= 16'h0000;
      sixteenthCount <= 4'h0;
      secondCount    <= 6'h00;
    end else if (refEdge) begin
      if (preWrap) begin
        preCount <= 16'h0000;
        sixteenthCount <= sixteenthCount + 4'h1;
        if (sixteenthCount == 4'(`GPTSC_SIXTEENTHS_SEC - 1)) begin
          secondCount <= (secondCount == 6'(`GPTSC_SECONDS_MIN - 1)) ? 6'h00
                                                                      : secondCount + 6'h01;
        end
      end else begin
        preCount <= preCount + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Registered tick pulses and square waves
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ticks <= '0;
    end else begin
      ticks.sixteenth <= preWrap;
      ticks.second    <= preWrap && (sixteenthCount == 4'(`GPTSC_SIXTEENTHS_SEC - 1));
      ticks.minute    <= preWrap && (sixteenthCount == 4'(`GPTSC_SIXTEENTHS_SEC - 1))
                         && (secondCount == 6'(`GPTSC_SECONDS_MIN - 1));
      ticks.sq16Hz    <= (preCount >= 16'(REF_PER_SIXTEENTH / 2));
      ticks.sq4Hz     <= sixteenthCount[1];
      ticks.sq1Hz     <= sixteenthCount[3];
    end
  end

endmodule : gptsc_tick_gen
`default_nettype wire

// file: core/gptsc_timer.sv
// One general-purpose countdown timer
`timescale 1ns/100ps
`default_nettype none
`include "gptsc_regs.svh"

module gptsc_timer (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  var  gptsc_pkg::gptsc_timer_cfg_s cfg,
  input  wire logic                        countWrite,
  input  wire logic                        reloadEvent,
  input  var  gptsc_pkg::gptsc_ticks_s     ticks,
  output logic [7:0]                       count,
  output logic                             timeout
);

  gptsc_pkg::gptsc_tmr_state_e state;
  logic                        startLast;
  logic                        tickHit;

  function automatic logic tick_pick(input gptsc_pkg::gptsc_tick_e sel,
                                     input gptsc_pkg::gptsc_ticks_s t);
    unique case (sel)
      gptsc_pkg::TICK_OFF:       tick_pick = 1'b0;
      gptsc_pkg::TICK_SIXTEENTH: tick_pick = t.sixteenth;
      gptsc_pkg::TICK_SECOND:    tick_pick = t.second;
      gptsc_pkg::TICK_MINUTE:    tick_pick = t.minute;
    endcase
  endfunction : tick_pick

  assign tickHit = tick_pick(cfg.tickSel, ticks);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      startLast <= 1'b0;
    end else begin
      startLast <= cfg.start;
    end
  end

  // ==========================================================
  // Count and state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= gptsc_pkg::TMR_STOPPED;
      count   <= `GPTSC_BYTE_ZERO;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (!cfg.start) begin
        state <= gptsc_pkg::TMR_STOPPED;
        if (countWrite) begin
          count <= cfg.loadValue;
        end
      end else if ((cfg.start && !startLast) || countWrite) begin
        count <= cfg.loadValue;
        state <= gptsc_pkg::TMR_RUNNING;
      end else begin
        unique case (state)
          gptsc_pkg::TMR_RUNNING: begin
            if (reloadEvent) begin
              count <= cfg.loadValue;
            end else if (tickHit) begin
              if (count <= `GPTSC_COUNT_ONE) begin
                timeout <= 1'b1;
                if (cfg.autoReload) begin
                  count <= cfg.loadValue;
                end else begin
                  count <= `GPTSC_BYTE_ZERO;
                  state <= gptsc_pkg::TMR_EXPIRED;
                end
              end else begin
                count <= count - `GPTSC_COUNT_ONE;
              end
            end
          end
          gptsc_pkg::TMR_EXPIRED: begin
            state <= gptsc_pkg::TMR_EXPIRED;
          end
          gptsc_pkg::TMR_STOPPED: begin
            state <= gptsc_pkg::TMR_STOPPED;
          end
          default: begin
            state <= gptsc_pkg::TMR_STOPPED;
          end
        endcase
      end
    end
  end

endmodule : gptsc_timer
`default_nettype wire

// file: core/gptsc_top.sv
// General-purpose timers and slow clock output, register file and pad mux
// Overview of operation
// - Setting timer B start loads bits 23:16 and starts the countdown.
// - Setting timer A start loads bits 15:8; clearing the bit stops it.
// - Reaching zero without reload sets status bit 3 (B) or bit 2 (A).
// - An enabled peripheral event reloads a running timer with its count.
// - Timeout raises the system interrupt only when enable bit 3 or 2 set.
// - Timer B auto-reload bit 6: 0 stops at zero, 1 reloads and continues.
// - Timer A auto-reload bit 2: 0 stops at zero, 1 reloads and continues.
// - Timer B tick bits 5:4: off, 1/16 s, 1 s, 1 minute.
// - Timer A tick bits 1:0 use the same tick encoding.
// - Output select: fixed level bit, 1 Hz, 4 Hz or 16 Hz clock.
// - Pad mux bit: 0 routes suspend-A status, 1 routes slow clock output.
// - Writing a count field loads the timer with the previous count, or the new one when start goes 0 to 1; reading returns live count.
`timescale 1ns/100ps
`default_nettype none
`include "gptsc_regs.svh"

module gptsc_top #(
  parameter int REF_PER_SIXTEENTH = `GPTSC_REF_PER_SIXTEENTH
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        slowRefClk,
  input  wire logic [7:0]  periphEvent,
  input  wire logic        suspendAStatus,
  output logic             sysMgmtInterrupt,
  output logic             sharedPad,
  output logic             slowClockOut
);

  // ==========================================================
  // Register state
  gptsc_pkg::gptsc_timer_cfg_s cfgA;
  gptsc_pkg::gptsc_timer_cfg_s cfgB;
  logic [7:0]                  miscOne;
  logic [7:0]                  miscTwo;
  logic [1:0]                  timeoutStatus;
  logic [1:0]                  timeoutEnable;
  logic [7:0]                  reloadEnable;
  logic                        fixedLevel;

  // ==========================================================
  // Internal wiring
  gptsc_pkg::gptsc_ticks_s     ticks;
  gptsc_pkg::gptsc_osel_e      outSel;
  logic [7:0]                  countA;
  logic [7:0]                  countB;
  logic                        timeoutA;
  logic                        timeoutB;
  logic                        reloadHit;
  logic                        ctrlWrite;
  logic                        next_slowClock;
  logic [31:0]                 next_rdata;
  logic [1:0]                  clearMask;

  function automatic logic addr_write(input logic [7:0] addr,
                                      input logic [7:0] off,
                                      input logic       we);
    addr_write = we && (addr == off);
  endfunction : addr_write

  assign ctrlWrite = addr_write(regAddr, `GPTSC_OFF_CTRL, regWrite);
  assign reloadHit = |(periphEvent & reloadEnable);
  assign outSel    = gptsc_pkg::gptsc_osel_e'(miscOne[`GPTSC_OSEL_HI:`GPTSC_OSEL_LO]);

  // ==========================================================
  // Timer control register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgA <= '0;
      cfgB <= '0;
    end else if (ctrlWrite) begin
      cfgB.loadValue  <= regWdata[`GPTSC_B_CNT_HI:`GPTSC_B_CNT_LO];
      cfgA.loadValue  <= regWdata[`GPTSC_A_CNT_HI:`GPTSC_A_CNT_LO];
      cfgB.start      <= regWdata[`GPTSC_B_START];
      cfgB.autoReload <= regWdata[`GPTSC_B_AUTO];
      cfgB.tickSel    <= gptsc_pkg::gptsc_tick_e'(
                           regWdata[`GPTSC_B_TICK_HI:`GPTSC_B_TICK_LO]);
      cfgA.start      <= regWdata[`GPTSC_A_START];
      cfgA.autoReload <= regWdata[`GPTSC_A_AUTO];
      cfgA.tickSel    <= gptsc_pkg::gptsc_tick_e'(
                           regWdata[`GPTSC_A_TICK_HI:`GPTSC_A_TICK_LO]);
    end
  end

  // ==========================================================
  // Misc configuration bytes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      miscOne <= `GPTSC_MISC1_RST;
    end else if (addr_write(regAddr, `GPTSC_OFF_MISC1, regWrite)) begin
      miscOne <= regWdata[7:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      miscTwo <= `GPTSC_MISC2_RST;
    end else if (addr_write(regAddr, `GPTSC_OFF_MISC2, regWrite)) begin
      miscTwo <= regWdata[7:0];
    end
  end

  // ==========================================================
  // Interrupt enable, reload enable and fixed output level
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timeoutEnable <= 2'b00;
    end else if (addr_write(regAddr, `GPTSC_OFF_SMIEN, regWrite)) begin
      timeoutEnable <= {regWdata[`GPTSC_STAT_B], regWdata[`GPTSC_STAT_A]};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reloadEnable <= `GPTSC_BYTE_ZERO;
    end else if (addr_write(regAddr, `GPTSC_OFF_RLDEN, regWrite)) begin
      reloadEnable <= regWdata[7:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fixedLevel <= 1'b0;
    end else if (addr_write(regAddr, `GPTSC_OFF_OUTLVL, regWrite)) begin
      fixedLevel <= regWdata[`GPTSC_OUTLVL_BIT];
    end
  end

  // ==========================================================
  // Timeout status, write one to clear, set wins
  always_comb begin
    clearMask = 2'b00;
    if (addr_write(regAddr, `GPTSC_OFF_STATUS, regWrite)) begin
      clearMask = {regWdata[`GPTSC_STAT_B], regWdata[`GPTSC_STAT_A]};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timeoutStatus <= 2'b00;
    end else begin
      timeoutStatus <= (timeoutStatus & ~clearMask) | {timeoutB, timeoutA};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sysMgmtInterrupt <= 1'b0;
    end else begin
      sysMgmtInterrupt <= |(timeoutStatus & timeoutEnable);
    end
  end

  // ==========================================================
  // Tick generator and the two timers
  gptsc_tick_gen #(
    .REF_PER_SIXTEENTH (REF_PER_SIXTEENTH)
  ) u_tick_gen (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .slowRefClk (slowRefClk),
    .ticks      (ticks)
  );

  gptsc_timer u_timer_a (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .cfg         (cfgA),
    .countWrite  (ctrlWrite),
    .reloadEvent (reloadHit),
    .ticks       (ticks),
    .count       (countA),
    .timeout     (timeoutA)
  );

  gptsc_timer u_timer_b (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .cfg         (cfgB),
    .countWrite  (ctrlWrite),
    .reloadEvent (reloadHit),
    .ticks       (ticks),
    .count       (countB),
    .timeout     (timeoutB)
  );

  // ==========================================================
  // Slow clock select and shared pad
  always_comb begin
    unique case (outSel)
      gptsc_pkg::OSEL_FIXED: next_slowClock = fixedLevel;
      gptsc_pkg::OSEL_1HZ:   next_slowClock = ticks.sq1Hz;
      gptsc_pkg::OSEL_4HZ:   next_slowClock = ticks.sq4Hz;
      gptsc_pkg::OSEL_16HZ:  next_slowClock = ticks.sq16Hz;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      slowClockOut <= 1'b0;
      sharedPad    <= 1'b0;
    end else begin
      slowClockOut <= next_slowClock;
      sharedPad    <= miscTwo[`GPTSC_PADMUX_BIT] ? next_slowClock
                                                 : suspendAStatus;
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = `GPTSC_WORD_ZERO;
    unique case (regAddr)
      `GPTSC_OFF_CTRL: begin
        next_rdata[`GPTSC_B_CNT_HI:`GPTSC_B_CNT_LO]   = countB;
        next_rdata[`GPTSC_A_CNT_HI:`GPTSC_A_CNT_LO]   = countA;
        next_rdata[`GPTSC_B_START]                    = cfgB.start;
        next_rdata[`GPTSC_B_AUTO]                     = cfgB.autoReload;
        next_rdata[`GPTSC_B_TICK_HI:`GPTSC_B_TICK_LO] = cfgB.tickSel;
        next_rdata[`GPTSC_A_START]                    = cfgA.start;
        next_rdata[`GPTSC_A_AUTO]                     = cfgA.autoReload;
        next_rdata[`GPTSC_A_TICK_HI:`GPTSC_A_TICK_LO] = cfgA.tickSel;
      end
      `GPTSC_OFF_MISC1:  next_rdata[7:0] = miscOne;
      `GPTSC_OFF_MISC2:  next_rdata[7:0] = miscTwo;
      `GPTSC_OFF_STATUS: begin
        next_rdata[`GPTSC_STAT_B] = timeoutStatus[1];
        next_rdata[`GPTSC_STAT_A] = timeoutStatus[0];
      end
      `GPTSC_OFF_SMIEN: begin
        next_rdata[`GPTSC_STAT_B] = timeoutEnable[1];
        next_rdata[`GPTSC_STAT_A] = timeoutEnable[0];
      end
      `GPTSC_OFF_RLDEN:  next_rdata[7:0] = reloadEnable;
      `GPTSC_OFF_OUTLVL: next_rdata[`GPTSC_OUTLVL_BIT] = fixedLevel;
      default:           next_rdata = `GPTSC_WORD_ZERO;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= `GPTSC_WORD_ZERO;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= `GPTSC_WORD_ZERO;
    end
  end

endmodule : gptsc_top
`default_nettype wire

// file: dv/gptsc_top_bench.sv
// Self-checking bench for the timer and slow clock block
`timescale 1ns/100ps
`default_nettype none
module gptsc_top_bench;
  localparam int REF = 4;
  logic        mclk           = 1'b0;
  logic        sys_rst        = 1'b1;
  logic [7:0]  regAddr        = 8'h00;
  logic [31:0] regWdata       = 32'h0;
  logic        regWrite       = 1'b0;
  logic        regRead        = 1'b0;
  logic        slowRefClk     = 1'b0;
  logic [7:0]  periphEvent    = 8'h00;
  logic        suspendAStatus = 1'b0;
  logic [31:0] regRdata;
  logic        sysMgmtInterrupt;
  logic        sharedPad;
  logic        slowClockOut;
  logic [31:0] rv;
  int          fails          = 0;
  int          checksDone     = 0;
  int          cyc            = 0;

  always #10 mclk = ~mclk;
  always #40 slowRefClk = ~slowRefClk;

  gptsc_top #(.REF_PER_SIXTEENTH(REF)) u_gptsc_top (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .slowRefClk(slowRefClk),
    .periphEvent(periphEvent), .suspendAStatus(suspendAStatus),
    .sysMgmtInterrupt(sysMgmtInterrupt), .sharedPad(sharedPad), .slowClockOut(slowClockOut));

  // ==========================================================
  // Bus and check helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rv = regRdata;
  endtask : rd

  task automatic settle(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : settle

  task automatic waitStat(input int b, input int lim, output int n);
    int t0;
    t0 = cyc;
    rd(8'h28);
    while (rv[b] !== 1'b1 && cyc - t0 < lim) rd(8'h28);
    n = cyc - t0;
  endtask : waitStat

  // ==========================================================
  // Scenarios
  task automatic tReset;
    rd(8'h94);
    chk("misc1 reset", 32'h88, rv);
    rd(8'h95);
    chk("misc2 reset", 32'h40, rv);
    rd(8'h28);
    chk("status reset", 0, rv);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00);
    chk("unmapped read", 0, rv);
  endtask : tReset

  task automatic tTickOff;
    wr(8'h90, 32'h0005_0080);
    repeat (100) @(posedge mclk);
    rd(8'h90);
    chk("held count", 8'h05, rv[23:16]);
    wr(8'h90, 32'h0005_0090);
    for (int i = 0; i < 30 && rv[23:16] === 8'h05; i++) rd(8'h90);
    chk("one step", 8'h04, rv[23:16]);
    wr(8'h90, 0);
  endtask : tTickOff

  task automatic tStartClear;
    wr(8'h90, 32'h0000_0909);
    wr(8'h90, 32'h0000_0901);
    repeat (80) @(posedge mclk);
    rd(8'h90);
    chk("halted count", 8'h09, rv[15:8]);
    rd(8'h28);
    chk("no timeout", 0, rv);
  endtask : tStartClear

  task automatic tReload;
    wr(8'h38, 32'h01);
    wr(8'h90, 32'h0000_0309);
    for (int i = 0; i < 24; i++) begin
      repeat (8) @(posedge mclk);
      periphEvent <= (i < 12) ? 8'h01 : 8'h02;
      @(posedge mclk);
      periphEvent <= 8'h00;
      if (i == 11) rd(8'h28);
      if (i == 11) chk("reload keeps alive", 0, rv);
    end
    rd(8'h28);
    chk("timeout status", 32'h4, rv);
    chk("masked interrupt", 0, sysMgmtInterrupt);
    wr(8'h2A, 32'h04);
    settle(3);
    chk("interrupt", 1, sysMgmtInterrupt);
    wr(8'h28, 32'h04);
    settle(3);
    chk("interrupt cleared", 0, sysMgmtInterrupt);
    wr(8'h2A, 0);
    wr(8'h90, 0);
  endtask : tReload

  task automatic tAuto;
    int n;
    wr(8'h90, 32'h0002_00D0);
    waitStat(3, 80, n);
    chk("first expiry", 32'h8, rv);
    wr(8'h2A, 32'h08);
    settle(3);
    chk("interrupt B", 1, sysMgmtInterrupt);
    wr(8'h2A, 0);
    wr(8'h28, 32'h08);
    rd(8'h90);
    chk("reloaded", 1, rv[23:16] != 8'h00);
    waitStat(3, 80, n);
    chk("second expiry", 32'h8, rv);
    wr(8'h90, 32'h0000_020D);
    wr(8'h28, 32'h0C);
    waitStat(2, 80, n);
    chk("auto expiry A", 32'h4, rv);
    rd(8'h90);
    chk("reloaded A", 1, rv[15:8] != 8'h00);
    wr(8'h90, 0);
    wr(8'h28, 32'h0C);
  endtask : tAuto

  task automatic tSlowOut;
    int e;
    int f;
    int x;
    logic p;
    logic q;
    wr(8'h4C, 32'h80);
    settle(3);
    chk("fixed high", 1, slowClockOut);
    wr(8'h4C, 0);
    @(posedge mclk);
    suspendAStatus <= 1'b1;
    settle(3);
    chk("fixed low", 0, slowClockOut);
    chk("pad suspend", 1, sharedPad);
    wr(8'h95, 32'h42);
    for (int i = 1; i < 4; i++) begin
      wr(8'h94, 32'h88 | i);
      settle(64);
      x = 4 << (2 * i - 2);
      e = 0;
      f = 0;
      p = slowClockOut;
      q = sharedPad;
      repeat (1024) begin
        @(negedge mclk);
        e += (slowClockOut && !p);
        f += (sharedPad && !q);
        p = slowClockOut;
        q = sharedPad;
      end
      chk("clock edges", 1, e >= x - 1 && e <= x + 1);
      chk("pad edges", 1, f >= x - 1 && f <= x + 1);
    end
    wr(8'h94, 32'h88);
    wr(8'h95, 32'h40);
  endtask : tSlowOut

  task automatic tTickRates;
    int n;
    int p;
    logic [1:0] t;
    logic isB;
    for (int i = 0; i < 4; i++) begin
      isB = (i > 1);
      t = (i == 3) ? 2'b11 : 2'(i % 2 + 1);
      p = (t == 2'b01) ? 4 * REF : (t == 2'b10) ? 64 * REF : 3840 * REF;
      wr(8'h90, isB ? {16'h0002, 8'h00, 2'b10, t, 4'h0}
                    : {16'h0000, 8'h02, 4'h0, 2'b10, t});
      waitStat(isB ? 3 : 2, 2 * p + 40, n);
      chk("expiry delay", 1, n >= p - 4 && n <= 2 * p + 16);
      chk("expiry status", isB ? 32'h8 : 32'h4, rv);
      repeat (40) @(posedge mclk);
      rd(8'h90);
      chk("stopped count", 0, isB ? rv[23:16] : rv[15:8]);
      wr(8'h90, 0);
      wr(8'h28, 32'h0C);
    end
  endtask : tTickRates

  // ==========================================================
  // Run control
  task automatic wrapUp;
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrapUp

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      wrapUp();
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    tReset();
    tTickOff();
    tStartClear();
    tReload();
    tAuto();
    tSlowOut();
    tTickRates();
    wrapUp();
  end
endmodule : gptsc_top_bench
`default_nettype wire

// file: dv/gptsc_top_properties.sv
// Concurrent checks on the timer and slow clock block ports
`timescale 1ns/100ps
`default_nettype none
module gptsc_top_properties #(
  parameter int REF_PER_SIXTEENTH = 2048
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        slowRefClk,
  input wire logic [7:0]  periphEvent,
  input wire logic        suspendAStatus,
  input wire logic        sysMgmtInterrupt,
  input wire logic        sharedPad,
  input wire logic        slowClockOut
);
  // ==========================================================
  // Register shadows and run counters
  logic [7:0] misc1, misc2, smiEn, outLvl, ctrlLo, runLen, oselAge;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      misc1  <= 8'h88;
      misc2  <= 8'h40;
      smiEn  <= 8'h00;
      outLvl <= 8'h00;
      ctrlLo <= 8'h00;
    end else if (regWrite) begin
      case (regAddr)
        8'h94:   misc1  <= regWdata[7:0];
        8'h95:   misc2  <= regWdata[7:0];
        8'h2A:   smiEn  <= regWdata[7:0];
        8'h4C:   outLvl <= regWdata[7:0];
        8'h90:   ctrlLo <= regWdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      runLen  <= 8'h00;
      oselAge <= 8'h00;
    end else begin
      runLen  <= $changed(slowClockOut) ? 8'h00 : runLen + 8'(runLen != 8'hFF);
      oselAge <= (regWrite && regAddr == 8'h94) ? 8'h00 : oselAge + 8'(oselAge != 8'hFF);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_rdata_idle_zero: assert property (
    !$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not zero outside read slot");
  a_ctrl_cfg_back: assert property (
    $past(regRead && regAddr == 8'h90) |->
    regRdata[31:24] == 8'h00 && regRdata[7:0] == $past(ctrlLo))
    else $error("timer control read back wrong");
  a_outsel_read_back: assert property (
    $past(regRead && regAddr == 8'h94) |-> regRdata == {24'h0, $past(misc1)})
    else $error("output select register read back wrong");
  a_padmux_read_back: assert property (
    $past(regRead && regAddr == 8'h95) |-> regRdata == {24'h0, $past(misc2)})
    else $error("pad mux register read back wrong");
  a_irq_gated: assert property (
    sysMgmtInterrupt |-> $past(smiEn[3:2]) != 2'b00)
    else $error("interrupt raised while timeout enables clear");
  a_pad_suspend: assert property (
    !misc2[1] && !$past(misc2[1]) && !$past(sys_rst) |-> sharedPad == $past(suspendAStatus))
    else $error("pad does not follow suspend status");
  a_fixed_level: assert property (
    misc1[1:0] == 2'b00 && $past(misc1[1:0]) == 2'b00 && !$past(sys_rst)
    |-> slowClockOut == $past(outLvl[7]))
    else $error("fixed output level wrong");
  a_fast_square_run: assert property (
    misc1[1:0] == 2'b11 && oselAge > 8'h3C |-> runLen < 8'h0C)
    else $error("16 Hz output stuck too long");

  c_irq: cover property (sysMgmtInterrupt);
  c_pad_clock: cover property (misc2[1] && $rose(sharedPad));
  c_fast_square: cover property (misc1[1:0] == 2'b11 && $rose(slowClockOut));
endmodule : gptsc_top_properties

bind gptsc_top gptsc_top_properties #(.REF_PER_SIXTEENTH(REF_PER_SIXTEENTH))
  u_gptsc_top_properties (
  .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .slowRefClk(slowRefClk),
  .periphEvent(periphEvent), .suspendAStatus(suspendAStatus),
  .sysMgmtInterrupt(sysMgmtInterrupt), .sharedPad(sharedPad), .slowClockOut(slowClockOut));
`default_nettype wire
